// file: include/ceca_pkg.sv
// Shared constants and types for the cascaded event counter array
package ceca_pkg;

   // ------------------------------------------------------------
   // Array shape
   // ------------------------------------------------------------
   localparam int NUM_CNT   = 18;  // Counters 0..17
   localparam int NUM_ESC   = 8;   // Two event-select registers per block
   localparam int NUM_EV    = 8;   // Processor event lines
   localparam int ESC_EV_W  = 3;   // Event line index width
   localparam int LAST_BLK_FIRST = 12;  // First counter of the last block
   localparam int LAST_BLK_IDX   = 3;   // Index of the last block

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] CNT_BASE = 12'h000;  // Counter values, one word each
   localparam logic [11:0] CFG_BASE = 12'h080;  // Counter configuration words
   localparam logic [11:0] ESC_BASE = 12'h100;  // Event-select words
   localparam logic [11:0] STAT_OFS = 12'h140;  // Sticky interrupt status
   localparam logic [11:0] MASK_OFS = 12'h144;  // Interrupt mask

   // ------------------------------------------------------------
   // Configuration word bit positions
   // ------------------------------------------------------------
   localparam int CFG_EN_BIT  = 0;   // Enable
   localparam int CFG_CAS_BIT = 1;   // Cascade
   localparam int CFG_IRQ_BIT = 2;   // Interrupt on wrap
   localparam int CFG_FRC_BIT = 3;   // Force overflow
   localparam int CFG_SEL_BIT = 4;   // Which of the block's two event selects
   localparam int CFG_EXT_BIT = 11;  // Extended chain enable
   localparam int CFG_OVF_BIT = 31;  // Sticky overflow flag

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0]         CNT_RST  = 32'h0000_0000;
   localparam logic [ESC_EV_W-1:0] ESC_RST  = 3'h0;
   localparam logic [17:0]         MASK_RST = 18'h00000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic ovf;      // overflow_sticky_flag
      logic ext;      // chain_c16_to_c12 and relatives
      logic sel;
      logic frc;
      logic irq;      // irq_on_wrap_flag
      logic cas;
      logic en;
   } ceca_cfg_s;

   localparam ceca_cfg_s CFG_RST = 7'h00;

   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_CNT  = 3'b001,
      K_CFG  = 3'b010,
      K_ESC  = 3'b011,
      K_STAT = 3'b100,
      K_MASK = 3'b101
   } ceca_kind_e;

   typedef struct packed {
      ceca_kind_e  kind;
      logic [4:0]  idx;
   } ceca_dec_s;

endpackage

// file: testbench/ceca_ev_model.sv
// Behavioural source of the processor event lines
`timescale 1ns/10ps
module ceca_ev_model (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic [ceca_pkg::NUM_EV-1:0] lvl,
   output logic      [ceca_pkg::NUM_EV-1:0] ev_in
);
   import ceca_pkg::*;
   // ------------------------------------------------------------
   // Event lines
   // ------------------------------------------------------------
   // Lines move only on the clock, so rise and fall see one latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_in <= '0;
      end else begin
         ev_in <= lvl;
      end
   end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the cascaded event counter array
`timescale 1ns/10ps
module tb_top;
   import ceca_pkg::*;
   typedef struct packed {
      logic [31:0] d;
      logic        e;
      logic        ck;
   } ceca_note_s;
   logic               pclk;
   logic               presetn;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [11:0]        paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [NUM_EV-1:0]  lvl;
   logic [NUM_EV-1:0]  ev_in;
   logic               perf_monitor_irq;
   ceca_note_s         notes[$];
   ceca_note_s         cur;
   int                 n_errors;
   int                 checks_done;
   int unsigned        seed_v;
   int unsigned        n;
   logic [31:0]        r;

   // ------------------------------------------------------------
   // Design, event source and clock
   // ------------------------------------------------------------
   ceca_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ev_in(ev_in), .perf_monitor_irq(perf_monitor_irq));
   ceca_ev_model ev_u (.pclk(pclk), .presetn(presetn), .lvl(lvl), .ev_in(ev_in));

   // Free-running bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [11:0] ca(input int i);
      return CNT_BASE + 12'(4 * i);
   endfunction
   function automatic logic [11:0] fa(input int i);
      return CFG_BASE + 12'(4 * i);
   endfunction

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One APB transfer; the expected answer goes on the queue first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      int k;
      ceca_note_s nt;
      nt.d = e;
      nt.e = er;
      nt.ck = !w;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      notes.push_back(nt);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      k = 1;
      while (pready !== 1'b1 && k < 20) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 20) begin
         n_errors++;
         end_of_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask

   // Holds one event line high for n cycles, then lets the sync drain
   task automatic pulse(input int ln, input int unsigned cnt);
      @(posedge pclk);
      lvl[ln] <= 1'b1;
      repeat (cnt) @(posedge pclk);
      lvl[ln] <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask

   task automatic irq_is(input logic e);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("perf_monitor_irq", 32'(perf_monitor_irq), 32'(e));
   endtask

   // ------------------------------------------------------------
   // Monitor: each completed transfer takes the oldest note
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (notes.size() == 0) begin
            chk("note_queue", 32'h0, 32'h1);
         end else begin
            cur = notes.pop_front();
            if (cur.ck) begin
               chk("prdata", prdata, cur.d);
            end
            chk("pslverr", 32'(pslverr), 32'(cur.e));
         end
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lvl = '0;
      n_errors = 0;
      checks_done = 0;
      seed_v = $urandom(32'h9046e25c);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and refused addresses
      rd(ca(17), CNT_RST);
      rd(fa(0), 32'h0);
      rd(MASK_OFS, 32'(MASK_RST));
      rd(STAT_OFS, 32'h0);
      apb(1'b0, STAT_OFS + 12'h008, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h200, 32'h1, 32'h0, 1'b1);
      // Wrap of counter 0 starts counter 2 through its cascade flag
      wr(ESC_BASE, 32'h0);
      wr(ca(0), 32'hffff_fffd);
      wr(fa(2), 32'h2);
      wr(fa(0), 32'h5);
      pulse(0, 5);
      rd(ca(0), 32'h2);
      rd(ca(2), 32'h2);
      rd(fa(0), 32'h8000_0005);
      irq_is(1'b0);
      wr(MASK_OFS, 32'h1);
      irq_is(1'b1);
      rd(STAT_OFS, 32'h1);
      rd(STAT_OFS, 32'h0);
      irq_is(1'b0);
      // Halting: own enable, then the source flag
      wr(fa(0), 32'h8000_0004);
      pulse(0, 3);
      rd(ca(0), 32'h2);
      rd(ca(2), 32'h5);
      wr(fa(0), 32'h4);
      pulse(0, 3);
      rd(ca(2), 32'h5);
      // Counter 16 starts 12 and 17 by the extended bit, never 14
      wr(ESC_BASE + 12'h018, 32'h1);
      wr(ca(16), 32'hffff_ffff);
      wr(fa(12), 32'h800);
      wr(fa(17), 32'h800);
      wr(fa(14), 32'h2);
      wr(fa(16), 32'h1);
      pulse(1, 3);
      rd(ca(16), 32'h2);
      rd(ca(12), 32'h2);
      rd(ca(17), 32'h2);
      rd(ca(14), 32'h0);
      wr(fa(13), 32'h800);
      rd(fa(13), 32'h0);
      // Second event select: 14 starts 16 by cascade, 17 starts 15 by extended bit
      wr(ESC_BASE + 12'h01c, 32'h3);
      wr(ca(14), 32'hffff_ffff);
      wr(ca(17), 32'hffff_ffff);
      wr(fa(16), 32'h12);
      wr(fa(15), 32'h810);
      wr(fa(14), 32'h11);
      wr(fa(17), 32'h11);
      pulse(3, 3);
      rd(ca(14), 32'h2);
      rd(ca(16), 32'h4);
      rd(ca(17), 32'h2);
      rd(ca(15), 32'h2);
      // Force overflow: every counted event is a wrap
      // One-cycle pulses never pass the synchroniser, so bursts are two or more
      n = 2 + ($urandom % 5);
      wr(ESC_BASE + 12'h008, 32'h2);
      wr(fa(4), 32'hd);
      pulse(2, n);
      rd(ca(4), 32'(n));
      rd(STAT_OFS, 32'h10);
      rd(fa(4), 32'h8000_000d);
      r = $urandom;
      wr(ca(6), r);
      rd(ca(6), r);
      end_of_test();
   end
endmodule

// file: verilog/ceca_counter.sv
// One wrapping event counter with load and force-overflow
`timescale 1ns/10ps
module ceca_counter #(
   parameter int W = 32
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         run,
   input  wire logic         ev,
   input  wire logic         force_ovf,
   output logic      [W-1:0] count,
   output logic              wrap
);
   import ceca_pkg::*;

   logic inc;

   // ------------------------------------------------------------
   // Increment and wrap detection
   // ------------------------------------------------------------
   // A load in the same cycle takes priority over the count
   assign inc  = run & ev & ~load;
   assign wrap = inc & (force_ovf | (&count));

   // Count register; all ones plus one rolls to zero and keeps going
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= CNT_RST[W-1:0];
      end else if (load) begin
         count <= load_val;
      end else if (inc) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// file: verilog/ceca_top.sv
// Cascaded event counter array with APB register access
`timescale 1ns/10ps
// Notes on behaviour
// - An enabled counter counts forever, wrapping from all ones to zero.
// - Every wrap sets a sticky overflow flag that only software clears.
// - Clearing the enable flag stops counting.
// - A cascade-started counter stops when its cascade or source overflow flag clears.
// - Eighteen counters in nine pairs and four blocks; last block holds 12 to 17.
// - Counters take events from their block's event-select registers.
// - The cascade flag lets a counter start from another pair in its block.
// - Counters 0 and 2, 1 and 3 cascade either way, in every block.
// - By the cascade flag, counter 16 starts only from 14, 17 only from 15; never the reverse.
// - Cascade set and enable clear: counting starts when the partner wraps.
// - Counters 16 and 17 never start a cascade through the cascade flag.
// - Bit 11 of last-block configs is the extended chain bit, reserved in two.
// - Counter 16 may start 12 and 17; counter 17 may start 15 and 16.
// - A set extended chain bit starts its target when 16 or 17 wraps.
// - Setting the enable flag starts counting until it is cleared.
// - Wrap with interrupt-on-wrap set raises the performance monitor interrupt when the counter's mask bit is set.
// - With force overflow set, every increment counts as a wrap.
module ceca_top #(
   parameter int W = 32
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [ceca_pkg::NUM_EV-1:0] ev_in,
   output logic                            perf_monitor_irq
);
   import ceca_pkg::*;

   // ------------------------------------------------------------
   // Chain topology helpers
   // ------------------------------------------------------------
   // Ordinary cascade source: same block, other pair, same slot
   function automatic int cas_src(input int i);
      if (i == 16) return 14;
      if (i == 17) return 15;
      return (i & ~3) | ((i & 3) ^ 2);
   endfunction

   // Extended chain source, or the counter itself when it has none
   function automatic int ext_src(input int i);
      unique case (i)
         12: return 16;
         15: return 17;
         16: return 17;
         17: return 16;
         default: return i;
      endcase
   endfunction

   // First event-select register of the counter's block
   function automatic int esc_base(input int i);
      return ((i < LAST_BLK_FIRST) ? (i / 4) : LAST_BLK_IDX) * 2;
   endfunction

   // Address decode for the register map
   function automatic ceca_dec_s decode(input logic [11:0] a);
      ceca_dec_s d;
      d.kind = K_NONE;
      d.idx  = 5'h00;
      if (a[1:0] == 2'h0) begin
         if (a >= CNT_BASE && a < CNT_BASE + 12'(4 * NUM_CNT)) begin
            d.kind = K_CNT;
            d.idx  = 5'((a - CNT_BASE) >> 2);
         end else if (a >= CFG_BASE && a < CFG_BASE + 12'(4 * NUM_CNT)) begin
            d.kind = K_CFG;
            d.idx  = 5'((a - CFG_BASE) >> 2);
         end else if (a >= ESC_BASE && a < ESC_BASE + 12'(4 * NUM_ESC)) begin
            d.kind = K_ESC;
            d.idx  = 5'((a - ESC_BASE) >> 2);
         end else if (a == STAT_OFS) begin
            d.kind = K_STAT;
         end else if (a == MASK_OFS) begin
            d.kind = K_MASK;
         end
      end
      return d;
   endfunction

   // ------------------------------------------------------------
   // State and wiring
   // ------------------------------------------------------------
   ceca_cfg_s               cfg_q    [NUM_CNT];
   logic [ESC_EV_W-1:0]     esc_q    [NUM_ESC];
   logic [W-1:0]            cnt      [NUM_CNT];
   logic [NUM_CNT-1:0]      cas_run_q;
   logic [NUM_CNT-1:0]      stat_q;
   logic [NUM_CNT-1:0]      mask_q;
   logic [NUM_CNT-1:0]      wrap;
   logic [NUM_CNT-1:0]      run;
   logic [NUM_CNT-1:0]      trig;
   logic [NUM_CNT-1:0]      keep;
   logic [NUM_CNT-1:0]      evsel;
   logic [NUM_CNT-1:0]      load;
   logic [NUM_CNT-1:0]      ovf;
   logic [NUM_EV-1:0]       ev_s1_q;
   logic [NUM_EV-1:0]       ev_s2_q;
   logic [NUM_EV-1:0]       ev_s3_q;
   logic [NUM_EV-1:0]       ev_f_q;
   logic [31:0]             prdata_q;
   logic                    err_q;
   logic                    irq_q;
   logic                    access;
   logic                    setup;
   ceca_dec_s               dec;
   logic [31:0]             rd_val;

   // ------------------------------------------------------------
   // Event line synchroniser
   // ------------------------------------------------------------
   // Three stages; a change is accepted once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
         ev_f_q  <= '0;
      end else begin
         ev_s1_q <= ev_in;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
         for (int k = 0; k < NUM_EV; k++) begin
            if (ev_s2_q[k] == ev_s3_q[k]) begin
               ev_f_q[k] <= ev_s3_q[k];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Zero wait states; read data and error are captured in the setup cycle
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign dec     = decode(paddr);
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = err_q & access;

   // Read data mux; reserved bits read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (dec.kind)
         K_CNT: begin
            rd_val[W-1:0] = cnt[dec.idx];
         end
         K_CFG: begin
            rd_val[CFG_EN_BIT]  = cfg_q[dec.idx].en;
            rd_val[CFG_CAS_BIT] = cfg_q[dec.idx].cas;
            rd_val[CFG_IRQ_BIT] = cfg_q[dec.idx].irq;
            rd_val[CFG_FRC_BIT] = cfg_q[dec.idx].frc;
            rd_val[CFG_SEL_BIT] = cfg_q[dec.idx].sel;
            rd_val[CFG_EXT_BIT] = cfg_q[dec.idx].ext;
            rd_val[CFG_OVF_BIT] = cfg_q[dec.idx].ovf;
         end
         K_ESC:  rd_val[ESC_EV_W-1:0] = esc_q[dec.idx[2:0]];
         K_STAT: rd_val[NUM_CNT-1:0] = stat_q;
         K_MASK: rd_val[NUM_CNT-1:0] = mask_q;
         K_NONE: rd_val = 32'h0000_0000;
      endcase
   end

   // Capture read data and decode error ahead of the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         err_q    <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
         err_q    <= (dec.kind == K_NONE);
      end
   end

   // Event-select and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < NUM_ESC; k++) begin
            esc_q[k] <= ESC_RST;
         end
         mask_q <= MASK_RST;
      end else if (access && pwrite) begin
         if (dec.kind == K_ESC) begin
            esc_q[dec.idx[2:0]] <= pwdata[ESC_EV_W-1:0];
         end
         if (dec.kind == K_MASK) begin
            mask_q <= pwdata[NUM_CNT-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------
   // Read clears only the bits that were returned; a new wrap wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
         irq_q  <= 1'b0;
      end else begin
         for (int k = 0; k < NUM_CNT; k++) begin
            if (wrap[k] && cfg_q[k].irq) begin
               stat_q[k] <= 1'b1;
            end else if (access && !pwrite && dec.kind == K_STAT && prdata_q[k]) begin
               stat_q[k] <= 1'b0;
            end
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign perf_monitor_irq = irq_q;

   // ------------------------------------------------------------
   // Counter slices
   // ------------------------------------------------------------
   for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      localparam int  SRC  = cas_src(i);
      localparam int  XSRC = ext_src(i);
      localparam bit  HASX = (XSRC != i);
      localparam int  EB   = esc_base(i);
      logic wr_cfg;

      assign wr_cfg   = access & pwrite & (dec.kind == K_CFG) & (dec.idx == 5'(i));
      assign load[i]  = access & pwrite & (dec.kind == K_CNT) & (dec.idx == 5'(i));
      assign ovf[i]   = cfg_q[i].ovf;
      assign evsel[i] = ev_f_q[esc_q[EB + int'(cfg_q[i].sel)]];

      // Start and hold terms for ordinary and extended chains
      assign trig[i] = (cfg_q[i].cas & wrap[SRC])
                     | (HASX & cfg_q[i].ext & wrap[XSRC]);
      assign keep[i] = (cfg_q[i].cas & ovf[SRC])
                     | (HASX & cfg_q[i].ext & ovf[XSRC]);
      assign run[i]  = cfg_q[i].en | cas_run_q[i];

      // Configuration word; a wrap in the write cycle still sets the flag
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cfg_q[i] <= CFG_RST;
         end else begin
            if (wr_cfg) begin
               cfg_q[i].en  <= pwdata[CFG_EN_BIT];
               cfg_q[i].cas <= pwdata[CFG_CAS_BIT];
               cfg_q[i].irq <= pwdata[CFG_IRQ_BIT];
               cfg_q[i].frc <= pwdata[CFG_FRC_BIT];
               cfg_q[i].sel <= pwdata[CFG_SEL_BIT];
               cfg_q[i].ext <= HASX & pwdata[CFG_EXT_BIT];
            end
            cfg_q[i].ovf <= wrap[i] | (wr_cfg ? pwdata[CFG_OVF_BIT] : cfg_q[i].ovf);
         end
      end

      // Chain-started run state
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cas_run_q[i] <= 1'b0;
         end else if (!cfg_q[i].en && trig[i]) begin
            cas_run_q[i] <= 1'b1;
         end else begin
            cas_run_q[i] <= cas_run_q[i] & keep[i];
         end
      end

      ceca_counter #(
         .W (W)
      ) u_cnt (
         .pclk      (pclk),
         .presetn   (presetn),
         .load      (load[i]),
         .load_val  (pwdata[W-1:0]),
         .run       (run[i]),
         .ev        (evsel[i]),
         .force_ovf (cfg_q[i].frc),
         .count     (cnt[i]),
         .wrap      (wrap[i])
      );

      // ---------------------------------------------------------
      // Checks
      // ---------------------------------------------------------
      a_wrap_to_zero: assert property (@(posedge pclk) disable iff (!presetn)
         run[i] && evsel[i] && !load[i] && (&cnt[i]) |=> cnt[i] == '0)
         else $error("counter did not wrap to zero");
      a_wrap_sets_ovf: assert property (@(posedge pclk) disable iff (!presetn)
         wrap[i] |=> ovf[i])
         else $error("wrap did not set overflow flag");
      a_ovf_sticky: assert property (@(posedge pclk) disable iff (!presetn)
         ovf[i] && !wr_cfg |=> ovf[i])
         else $error("overflow flag dropped without a write");
      a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
         !run[i] && !load[i] |=> cnt[i] == $past(cnt[i]))
         else $error("halted counter changed");
      a_enable_counts: assert property (@(posedge pclk) disable iff (!presetn)
         cfg_q[i].en && evsel[i] && !load[i] && !(&cnt[i])
         |=> cnt[i] == $past(cnt[i]) + 1'b1)
         else $error("enabled counter did not increment");
      a_chain_start: assert property (@(posedge pclk) disable iff (!presetn)
         !cfg_q[i].en && cfg_q[i].cas && wrap[SRC] |=> run[i])
         else $error("cascade did not start counter");
      a_chain_stop: assert property (@(posedge pclk) disable iff (!presetn)
         cas_run_q[i] && !keep[i] && !trig[i] |=> !cas_run_q[i])
         else $error("cascade run survived cleared flag");
      a_ext_reserved: assert property (@(posedge pclk) disable iff (!presetn)
         !HASX |-> !cfg_q[i].ext)
         else $error("reserved chain bit is set");
      a_force_wraps: assert property (@(posedge pclk) disable iff (!presetn)
         run[i] && evsel[i] && !load[i] && cfg_q[i].frc |-> wrap[i] ##1 ovf[i])
         else $error("forced overflow missing");
      a_irq_status: assert property (@(posedge pclk) disable iff (!presetn)
         wrap[i] && cfg_q[i].irq |=> stat_q[i])
         else $error("wrap did not set interrupt status");
   end

   // ------------------------------------------------------------
   // Scenario coverage
   // ------------------------------------------------------------
   c_chain_start: cover property (@(posedge pclk) disable iff (!presetn)
      !cfg_q[2].en && trig[2] ##1 cas_run_q[2]);
   c_ext_start: cover property (@(posedge pclk) disable iff (!presetn)
      cfg_q[12].ext && wrap[16] ##1 cas_run_q[12]);
   c_irq_raise: cover property (@(posedge pclk) disable iff (!presetn)
      !perf_monitor_irq ##1 perf_monitor_irq);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pslverr);

endmodule
